// ===== core/hybrid_physical_rng_core.sv
// hybrid physical random generator: raw bit health tests, adaptive
// compression, cryptographic post-processor and a two-entry output buffer
// assumes RAW_BIT is an asynchronous noise pin and the consumer uses
// RNG_VALID/RNG_READY handshaking on REF_CLK
`timescale 1ns/1ps
`default_nettype none
`include "rng_defs.svh"

// Behaviour
// - total-failure test runs from start; after total failure no words leave.
// - total failure mid-run flushes every value built from later raw bits.
// - online test catches statistical defects at start and during operation.
// - no output before power-up test passes and seeding completes.
// - a flagged defect stops all random output.
// - every raw bit is examined, not samples at intervals.
// - post-processor has cryptographic state update and output functions.
// - output bit rate never exceeds input entropy bit rate.
// - random numbers leave as 32-bit words.
// - post-processor input comes only from the internal physical source.
// - raw bits compressed adaptively, ratio chosen by an entropy estimator.
// - each delivered source byte is meant to carry over 7.976 bits entropy.
module hybrid_physical_rng_core import rng_pkg::*; #(
  parameter int RAW_DIV = `RNG_RAW_DIV,
  parameter int TF_RUN = `RNG_TF_RUN,
  parameter int RC_LIMIT = `RNG_RC_LIMIT,
  parameter int APT_WIN = `RNG_APT_WIN,
  parameter int APT_LO = `RNG_APT_LO,
  parameter int APT_HI = `RNG_APT_HI,
  parameter int EST_TIGHT = `RNG_EST_TIGHT,
  parameter int SEED_BYTES = `RNG_SEED_BYTES,
  parameter int MIX_ROUNDS = `RNG_MIX_ROUNDS
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic RAW_BIT,
  input wire logic RNG_READY,
  output logic [`RNG_WORD_W-1:0] RNG_DATA,
  output logic RNG_VALID,
  output logic RNG_ACTIVE,
  output logic FAIL_TOTAL,
  output logic FAIL_DEFECT
);
  localparam int DW = $clog2(RAW_DIV + 1);
  localparam int RW = $clog2(TF_RUN + 1);
  localparam int WW = $clog2(APT_WIN + 1);
  localparam int SW = $clog2(SEED_BYTES + 1);
  localparam int MW = $clog2(MIX_ROUNDS + 1);
  localparam int CW = $clog2(`RNG_CREDIT_MAX + 1);
  localparam int STW = `RNG_STATE_W;

  function automatic logic [31:0] rotl(input logic [31:0] v, input int n);
    rotl = (v << n) | (v >> (32 - n));
  endfunction : rotl

  // one add-rotate-xor round over four lanes
  function automatic logic [STW-1:0] mix(input logic [STW-1:0] s);
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic [31:0] d;
    a = s[127:96];
    b = s[95:64];
    c = s[63:32];
    d = s[31:0];
    a = a + b;
    d = rotl(d ^ a, 16);
    c = c + d;
    b = rotl(b ^ c, 12);
    a = a + b;
    d = rotl(d ^ a, 8);
    c = c + d;
    b = rotl(b ^ c, 7);
    mix = {b, c, d, a};
  endfunction : mix

  // one-way output: lanes are folded so the state cannot be read back
  function automatic logic [31:0] out_fn(input logic [STW-1:0] s);
    logic [STW-1:0] t;
    t = mix(s);
    out_fn = (t[127:96] + s[95:64]) ^ (t[63:32] + s[31:0]);
  endfunction : out_fn

  // raw pin synchroniser, change accepted once stages two and three agree
  logic sync1;
  logic sync2;
  logic sync3;
  logic raw_q;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      raw_q <= 1'b0;
    end else begin
      sync1 <= RAW_BIT;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) raw_q <= sync3;
    end
  end

  // sample-rate enable
  logic [DW-1:0] div_cnt;
  wire raw_en = (div_cnt == DW'(RAW_DIV - 1));
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) div_cnt <= '0;
    else div_cnt <= raw_en ? '0 : div_cnt + 1'b1;
  end

  // health tests on every raw sample
  logic last_bit;
  logic [RW-1:0] run_len;
  logic [WW-1:0] win_cnt;
  logic [WW-1:0] ones;
  logic startup_ok;
  logic [2:0] ratio;
  health_s health;
  gen_state_e st;

  wire same_bit = (raw_q == last_bit);
  wire [RW-1:0] run_next = same_bit ? run_len + 1'b1 : RW'(1);
  wire win_end = raw_en && (win_cnt == WW'(APT_WIN - 1));
  wire [WW-1:0] ones_tot = ones + WW'(raw_q);
  wire [WW-1:0] half_win = WW'(APT_WIN / 2);
  wire [WW-1:0] dev = (ones_tot > half_win) ? ones_tot - half_win : half_win - ones_tot;
  wire tf_evt = raw_en && (run_next >= RW'(TF_RUN));
  wire rc_evt = raw_en && (run_next >= RW'(RC_LIMIT));
  wire apt_evt = win_end && ((ones_tot < WW'(APT_LO)) || (ones_tot > WW'(APT_HI)));
  wire fail_now = tf_evt || rc_evt || apt_evt || health.total || health.defect;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      last_bit <= 1'b0;
      run_len <= '0;
    end else if (raw_en) begin
      last_bit <= raw_q;
      run_len <= (run_next >= RW'(TF_RUN)) ? RW'(TF_RUN) : run_next;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      win_cnt <= '0;
      ones <= '0;
    end else if (raw_en) begin
      win_cnt <= win_end ? '0 : win_cnt + 1'b1;
      ones <= win_end ? '0 : ones_tot;
    end
  end

  // sticky until reset; only reset clears a health failure
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) health <= '0;
    else begin
      if (tf_evt) health.total <= 1'b1;
      if (rc_evt || apt_evt) health.defect <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) startup_ok <= 1'b0;
    else if (win_end && !fail_now) startup_ok <= 1'b1;
  end

  // entropy estimator: a balanced window earns the lighter compression
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) ratio <= 3'(`RNG_RATIO_COARSE);
    else if (win_end) ratio <= (dev < WW'(EST_TIGHT)) ? 3'(`RNG_RATIO_FINE)
                                                      : 3'(`RNG_RATIO_COARSE);
  end

  // adaptive compression into bytes, fed only by the internal source
  logic [2:0] fold_cnt;
  logic fold_acc;
  logic [`RNG_BYTE_W-1:0] byte_sr;
  logic [2:0] bit_cnt;
  logic byte_v;
  logic [`RNG_BYTE_W-1:0] byte_q;
  wire collect = raw_en && (st == ST_SEED || st == ST_RUN) && !fail_now;
  wire fold_done = (fold_cnt == ratio - 3'd1);
  wire fold_bit = fold_acc ^ raw_q;
  wire byte_done = fold_done && (bit_cnt == 3'd7);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fold_cnt <= '0;
      fold_acc <= 1'b0;
      bit_cnt <= '0;
      byte_sr <= '0;
    end else if (fail_now) begin
      fold_cnt <= '0;
      fold_acc <= 1'b0;
      bit_cnt <= '0;
    end else if (collect) begin
      fold_cnt <= fold_done ? '0 : fold_cnt + 1'b1;
      fold_acc <= fold_done ? 1'b0 : fold_bit;
      if (fold_done) begin
        byte_sr <= {byte_sr[6:0], fold_bit};
        bit_cnt <= bit_cnt + 1'b1;
      end
    end
  end

  // ratio chosen so each byte is meant to carry over 7.976 bits of entropy
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      byte_v <= 1'b0;
      byte_q <= '0;
    end else begin
      byte_v <= collect && byte_done;
      byte_q <= {byte_sr[6:0], fold_bit};
    end
  end

  // post-processor state, seeding and word generation
  logic [STW-1:0] dstate;
  logic [SW-1:0] seed_cnt;
  logic [CW-1:0] credit;
  logic busy;
  logic [MW-1:0] rnd;
  logic in_ready;
  wire seeded = byte_v && (seed_cnt == SW'(SEED_BYTES - 1));
  wire start = (st == ST_RUN) && !fail_now && !busy && in_ready
               && (credit >= CW'(`RNG_WORD_W));
  wire word_push = busy && (rnd == MW'(MIX_ROUNDS - 1)) && !fail_now;
  wire [`RNG_WORD_W-1:0] word_val = out_fn(dstate);
  wire credit_add = byte_v && (st == ST_RUN)
                    && (credit <= CW'(`RNG_CREDIT_MAX - `RNG_BYTE_W));
  wire [STW-1:0] absorbed = dstate ^ {{(STW - `RNG_BYTE_W){1'b0}}, byte_q};
  wire [STW-1:0] next_dstate = byte_v ? mix(absorbed) : (busy ? mix(dstate) : dstate);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) dstate <= '0;
    else dstate <= next_dstate;
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) seed_cnt <= '0;
    else if (st == ST_SEED && byte_v) seed_cnt <= seed_cnt + 1'b1;
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy <= 1'b0;
      rnd <= '0;
    end else if (fail_now) begin
      busy <= 1'b0;
      rnd <= '0;
    end else if (start) begin
      busy <= 1'b1;
      rnd <= '0;
    end else if (busy) begin
      busy <= !word_push;
      rnd <= rnd + 1'b1;
    end
  end

  // entropy credit: eight bits per byte absorbed in the run state, 32 spent per word
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) credit <= '0;
    else if (fail_now) credit <= '0;
    else credit <= credit + (credit_add ? CW'(`RNG_BYTE_W) : CW'(0))
                   - (start ? CW'(`RNG_WORD_W) : CW'(0));
  end

  // sequencing
  gen_state_e next_st;
  always_comb begin
    next_st = st;
    case (st)
      ST_STARTUP: if (fail_now) next_st = ST_FAIL;
                  else if (startup_ok) next_st = ST_SEED;
      ST_SEED: if (fail_now) next_st = ST_FAIL;
               else if (seeded) next_st = ST_RUN;
      ST_RUN: if (fail_now) next_st = ST_FAIL;
      ST_FAIL: next_st = ST_FAIL;
      default: next_st = ST_FAIL;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) st <= ST_STARTUP;
    else st <= next_st;
  end

  // two-entry buffer; entry 0 drives the outputs, entry 1 absorbs a stall
  word_s buf_q [0:1];
  wire pop = buf_q[0].valid && RNG_READY;
  wire head_free = !buf_q[0].valid || pop;
  word_s in_word;
  assign in_word = '{valid: 1'b1, data: word_val};

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else if (fail_now) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      if (head_free) begin
        if (buf_q[1].valid) buf_q[0] <= buf_q[1];
        else if (word_push) buf_q[0] <= in_word;
        else buf_q[0].valid <= 1'b0;
      end
      if (head_free && buf_q[1].valid) buf_q[1] <= word_push ? in_word : '0;
      else if (!head_free && word_push) buf_q[1] <= in_word;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) in_ready <= 1'b0;
    else in_ready <= !fail_now && !(buf_q[1].valid && !pop) && !busy
                     && !(word_push && buf_q[0].valid && !pop);
  end

  // status flags registered for the ports
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RNG_ACTIVE <= 1'b0;
      FAIL_TOTAL <= 1'b0;
      FAIL_DEFECT <= 1'b0;
    end else begin
      RNG_ACTIVE <= (next_st == ST_RUN);
      FAIL_TOTAL <= health.total || tf_evt;
      FAIL_DEFECT <= health.defect || rc_evt || apt_evt;
    end
  end

  assign RNG_DATA = buf_q[0].data;
  assign RNG_VALID = buf_q[0].valid;
endmodule : hybrid_physical_rng_core
`default_nettype wire

// ===== core/rng_defs.svh
// timing counts, limits and widths of the hybrid random generator core
// assumes inclusion by bare name from the package and the core
`ifndef RNG_DEFS_SVH
`define RNG_DEFS_SVH
`define RNG_WORD_W 32
`define RNG_BYTE_W 8
`define RNG_RAW_DIV 4
`define RNG_TF_RUN 48
`define RNG_RC_LIMIT 32
`define RNG_APT_WIN 512
`define RNG_APT_LO 176
`define RNG_APT_HI 336
`define RNG_EST_TIGHT 24
`define RNG_RATIO_FINE 2
`define RNG_RATIO_COARSE 4
`define RNG_SEED_BYTES 16
`define RNG_MIX_ROUNDS 4
`define RNG_CREDIT_MAX 128
`define RNG_STATE_W 128
`endif

// ===== core/rng_pkg.sv
// types shared by the hybrid random generator core
// assumes rng_defs.svh on the include path
`include "rng_defs.svh"
package rng_pkg;
  typedef enum logic [1:0] {ST_STARTUP, ST_SEED, ST_RUN, ST_FAIL} gen_state_e;
  typedef struct packed {
    logic valid;
    logic [`RNG_WORD_W-1:0] data;
  } word_s;
  typedef struct packed {
    logic total;
    logic defect;
  } health_s;
endpackage : rng_pkg

// ===== verification/hybrid_physical_rng_core_sva.sv
// port checker for the hybrid random generator core
// assumes bind onto the core, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "rng_defs.svh"
module hybrid_physical_rng_core_sva (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic RAW_BIT,
  input wire logic RNG_READY,
  input wire logic [`RNG_WORD_W-1:0] RNG_DATA,
  input wire logic RNG_VALID,
  input wire logic RNG_ACTIVE,
  input wire logic FAIL_TOTAL,
  input wire logic FAIL_DEFECT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_failed;
    FAIL_TOTAL || FAIL_DEFECT;
  endsequence
  sequence s_stalled;
    RNG_VALID && !RNG_READY;
  endsequence
  a_start_quiet: assert property ($rose(RST_N) |-> (!RNG_ACTIVE && !RNG_VALID)[*8])
    else $error("output seen right after reset");
  a_valid_active: assert property (RNG_VALID |-> RNG_ACTIVE || $past(RNG_ACTIVE))
    else $error("word valid outside run state");
  a_fail_flush: assert property (s_failed |=> !RNG_VALID)
    else $error("word valid after failure");
  a_fail_idle: assert property (s_failed |-> ##[0:1] !RNG_ACTIVE)
    else $error("still running after failure");
  a_total_sticky: assert property (FAIL_TOTAL |=> FAIL_TOTAL)
    else $error("total failure flag cleared");
  a_defect_sticky: assert property (FAIL_DEFECT |=> FAIL_DEFECT)
    else $error("defect flag cleared");
  a_total_defect: assert property (FAIL_TOTAL |-> FAIL_DEFECT)
    else $error("total failure without defect");
  a_word_hold: assert property (s_stalled |=> (RNG_VALID && $stable(RNG_DATA)) or s_failed)
    else $error("stalled word changed");
  a_credit_gap: assert property ($rose(RNG_ACTIVE) |-> (!RNG_VALID)[*8])
    else $error("word before credit gathered");
  a_stop_cause: assert property ($fell(RNG_ACTIVE) |-> FAIL_TOTAL || FAIL_DEFECT)
    else $error("run state left without failure");
endmodule : hybrid_physical_rng_core_sva
bind hybrid_physical_rng_core hybrid_physical_rng_core_sva hybrid_physical_rng_core_sva_inst (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .RAW_BIT(RAW_BIT), .RNG_READY(RNG_READY),
  .RNG_DATA(RNG_DATA), .RNG_VALID(RNG_VALID), .RNG_ACTIVE(RNG_ACTIVE),
  .FAIL_TOTAL(FAIL_TOTAL), .FAIL_DEFECT(FAIL_DEFECT));
`default_nettype wire

// ===== verification/hybrid_physical_rng_core_test.sv
// self-checking bench for the hybrid random generator core
// assumes core, checker and consumer model compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "rng_defs.svh"
module hybrid_physical_rng_core_test import rng_pkg::*;;
  logic REF_CLK, RST_N, RAW_BIT, RNG_READY, RNG_VALID, RNG_ACTIVE, FAIL_TOTAL, FAIL_DEFECT;
  logic stall, repeat_seen;
  logic [`RNG_WORD_W-1:0] RNG_DATA;
  logic [31:0] lfsr_state = 32'h306A7418;
  int miscompares = 0;
  int n_compared = 0;
  int ncyc = 0;
  int pops, mode, snap, t0, i;
  // short window and seed keep the run brief
  hybrid_physical_rng_core #(.APT_WIN(64), .APT_LO(16), .APT_HI(48), .EST_TIGHT(8),
    .SEED_BYTES(2)) hybrid_physical_rng_core_inst (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .RAW_BIT(RAW_BIT), .RNG_READY(RNG_READY), .RNG_DATA(RNG_DATA), .RNG_VALID(RNG_VALID),
    .RNG_ACTIVE(RNG_ACTIVE), .FAIL_TOTAL(FAIL_TOTAL), .FAIL_DEFECT(FAIL_DEFECT));
  rng_consumer_model rng_consumer_model_inst (.clk(REF_CLK), .stall(stall), .valid(RNG_VALID),
    .data(RNG_DATA), .ready(RNG_READY), .pops(pops), .repeat_seen(repeat_seen));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // fastest credit: fine ratio, one bit per two samples
  function automatic int max_words(input int cycles);
    return cycles / (`RNG_RAW_DIV * `RNG_RATIO_FINE * `RNG_WORD_W) + 1;
  endfunction : max_words
  initial begin
    REF_CLK = 1'h0;
    forever #10 REF_CLK = ~REF_CLK;
  end
  // mode 0 random, 1 stuck high, 2 biased with short runs
  always @(posedge REF_CLK) begin
    if (ncyc % `RNG_RAW_DIV == 0) begin
      lfsr_state <= lfsr_next(lfsr_state);
      RAW_BIT <= (mode == 1) ? 1'h1 : (mode == 2) ? (ncyc % 124 < 120) : lfsr_state[0];
    end
    ncyc <= ncyc + 1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (exp !== got) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  // reset edges land on the rising edge so no input moves off the clock
  task automatic do_reset(input int m);
    @(posedge REF_CLK);
    RST_N <= 1'h0;
    mode <= m;
    repeat (6) @(posedge REF_CLK);
    RST_N <= 1'h1;
    #1;
  endtask : do_reset
  task automatic final_report();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge REF_CLK);
    miscompares++;
    final_report();
  end
  initial begin
    RST_N = 1'h0;
    stall = 1'h0;
    mode = 0;
    do_reset(0);
    tick(100);
    check("valid in startup", 32'h0, RNG_VALID);
    check("active in startup", 32'h0, RNG_ACTIVE);
    for (i = 0; i < 3000 && RNG_ACTIVE !== 1'h1; i++) tick(1);
    check("active after seed", 32'h1, RNG_ACTIVE);
    t0 = ncyc;
    snap = pops;
    stall <= 1'h1;
    tick(1500);
    check("word held in stall", 32'h1, RNG_VALID);
    stall <= 1'h0;
    tick(3000);
    check("words delivered", 32'h1, pops - snap > 3);
    check("rate bound", 32'h1, pops - snap <= max_words(ncyc - t0));
    check("no false failure", 32'h0, {FAIL_TOTAL, FAIL_DEFECT});
    check("neighbours differ", 32'h0, repeat_seen);
    $display("test good_run done");
    mode <= 1;
    for (i = 0; i < 600 && FAIL_TOTAL !== 1'h1; i++) tick(1);
    tick(2);
    snap = pops;
    check("total flag", 32'h1, FAIL_TOTAL);
    check("defect flag", 32'h1, FAIL_DEFECT);
    tick(400);
    check("words after failure", snap, pops);
    check("active after failure", 32'h0, RNG_ACTIVE);
    check("data after failure", 32'h0, RNG_DATA);
    $display("test stuck_run done");
    do_reset(1);
    snap = pops;
    tick(800);
    check("total at start", 32'h1, FAIL_TOTAL);
    check("never active", 32'h0, RNG_ACTIVE);
    check("no words", snap, pops);
    $display("test stuck_start done");
    do_reset(2);
    tick(800);
    check("bias defect", 32'h1, FAIL_DEFECT);
    check("bias not total", 32'h0, FAIL_TOTAL);
    check("bias inactive", 32'h0, RNG_ACTIVE);
    $display("test biased done");
    final_report();
  end
endmodule : hybrid_physical_rng_core_test
`default_nettype wire

// ===== verification/rng_consumer_model.sv
// consumer of random words with random stalls
// assumes valid/ready handshake sampled on the core clock
`timescale 1ns/1ps
`default_nettype none
module rng_consumer_model (
  input wire logic clk,
  input wire logic stall,
  input wire logic valid,
  input wire logic [31:0] data,
  output logic ready,
  output int pops,
  output logic repeat_seen
);
  logic [31:0] last;
  logic [7:0] lf;
  always @(posedge clk) begin
    lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    ready <= !stall && lf[0];
    if (valid && ready) begin
      pops <= pops + 1;
      last <= data;
      // identical neighbours hint at a stuck mixer
      if (pops > 0 && data === last) repeat_seen <= 1'h1;
    end
  end
  initial begin
    lf = 8'hA5;
    ready = 1'h0;
    pops = 0;
    repeat_seen = 1'h0;
    last = 32'h0;
  end
endmodule : rng_consumer_model
`default_nettype wire
